// File: common/tsca_pkg.sv
package tsca_pkg;

	// ---------------------------------------------------------------
	// Register indices
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_TEMP = 8'h00;
	localparam logic [7:0] ADDR_CTRL = 8'h01;
	localparam logic [7:0] ADDR_TLOW = 8'h02;
	localparam logic [7:0] ADDR_THIGH = 8'h03;

	// ---------------------------------------------------------------
	// Values after reset, write masks and reserved read-back ones
	// ---------------------------------------------------------------
	localparam logic [15:0] CTRL_RST = 16'h60A0;
	localparam logic [15:0] TLOW_RST = 16'h4B00;
	localparam logic [15:0] THIGH_RST = 16'h5000;
	localparam logic [15:0] CTRL_WMASK = 16'h1FD0;
	localparam logic [15:0] CTRL_RSV_ONES = 16'h6000;

	// ---------------------------------------------------------------
	// Field positions of operation_control
	// ---------------------------------------------------------------
	localparam int B_ONESHOT = 15;
	localparam int B_FAULT = 11;
	localparam int B_POL = 10;
	localparam int B_MODE = 9;
	localparam int B_SD = 8;
	localparam int B_RATE = 6;
	localparam int B_FLAG = 5;
	localparam int B_EXT = 4;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int BASE_PERIOD_US = 125000;
	localparam int BASE_CYC = BASE_PERIOD_US * CLK_MHZ;
	localparam logic [5:0] RATE_MULT_0 = 6'h20;
	localparam logic [5:0] RATE_MULT_1 = 6'h08;
	localparam logic [5:0] RATE_MULT_2 = 6'h02;
	localparam logic [5:0] RATE_MULT_3 = 6'h01;

	// ---------------------------------------------------------------
	// Fault queue depths in conversions
	// ---------------------------------------------------------------
	localparam int FQ_DEPTH_0 = 1;
	localparam int FQ_DEPTH_1 = 2;
	localparam int FQ_DEPTH_2 = 4;
	localparam int FQ_DEPTH_3 = 6;

endpackage

// File: src/tsca_fault_q.sv
`timescale 1ns/1ps
module tsca_fault_q #(
	parameter int CW = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Conversion results
	input wire logic sample,
	input wire logic hi_cond,
	input wire logic lo_cond,
	input wire logic [1:0] depth,
	// Qualified status
	output logic upd,
	output logic hi_q,
	output logic lo_q
);

	typedef struct packed {
		logic [CW-1:0] hi_cnt;
		logic [CW-1:0] lo_cnt;
		logic upd;
		logic hi_q;
		logic lo_q;
	} tsca_fq_t;

	tsca_fq_t st_r, st_nxt;

	function automatic logic [CW-1:0] need(input logic [1:0] d);
		unique case (d)
			2'h0: need = CW'(tsca_pkg::FQ_DEPTH_0);
			2'h1: need = CW'(tsca_pkg::FQ_DEPTH_1);
			2'h2: need = CW'(tsca_pkg::FQ_DEPTH_2);
			2'h3: need = CW'(tsca_pkg::FQ_DEPTH_3);
		endcase
	endfunction

	// Counters saturate so a long run of faults never wraps back below the depth.
	always_comb begin
		st_nxt = st_r;
		st_nxt.upd = sample;
		if (sample) begin
			st_nxt.hi_cnt = !hi_cond ? '0 : (&st_r.hi_cnt ? st_r.hi_cnt : st_r.hi_cnt + CW'(1));
			st_nxt.lo_cnt = !lo_cond ? '0 : (&st_r.lo_cnt ? st_r.lo_cnt : st_r.lo_cnt + CW'(1));
			st_nxt.hi_q = st_nxt.hi_cnt >= need(depth);
			st_nxt.lo_q = st_nxt.lo_cnt >= need(depth);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign upd = st_r.upd;
	assign hi_q = st_r.hi_q;
	assign lo_q = st_r.lo_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_fq_depth;
		@(posedge clk) disable iff (rst)
		st_r.upd && $stable(depth) |-> (st_r.hi_q == (st_r.hi_cnt >= need(depth)));
	endproperty
	a_fq_depth: assert property (p_fq_depth) else $error("fault queue level disagrees with count");

	property p_fq_break;
		@(posedge clk) disable iff (rst)
		sample && !hi_cond |=> st_r.hi_cnt == '0 && !st_r.hi_q;
	endproperty
	a_fq_break: assert property (p_fq_break) else $error("fault run not restarted");

endmodule

// File: src/tsca_top.sv
`timescale 1ns/1ps
module tsca_top #(
	parameter int unsigned BASE_CYC = tsca_pkg::BASE_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port from the serial bus engine
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// Converter handshake
	output logic adc_start,
	input wire logic adc_done,
	input wire logic [12:0] adc_data,
	// Limit event pin level
	output logic alert_out
);

	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] tlow;
		logic [15:0] thigh;
		logic [12:0] temp;
		logic busy;
		logic landed;
		logic [31:0] tick;
		logic [5:0] per_cnt;
		logic comp;
		logic ev;
		logic ev_dir;
		logic adc_start;
		logic alert;
		logic [15:0] rdata;
	} tsca_st_t;

	tsca_st_t st_r, st_nxt;

	// ---------------------------------------------------------------
	// Decoding helpers
	// ---------------------------------------------------------------
	function automatic logic [5:0] rate_mult(input logic [1:0] r);
		unique case (r)
			2'h0: rate_mult = tsca_pkg::RATE_MULT_0;
			2'h1: rate_mult = tsca_pkg::RATE_MULT_1;
			2'h2: rate_mult = tsca_pkg::RATE_MULT_2;
			2'h3: rate_mult = tsca_pkg::RATE_MULT_3;
		endcase
	endfunction

	// A limit register's value as a 13-bit signed number in the current format.
	function automatic logic [12:0] lim_raw(input logic [15:0] v, input logic ext);
		lim_raw = ext ? v[15:3] : {v[15], v[15:4]};
	endfunction

	function automatic logic [15:0] lim_read(input logic [15:0] v, input logic ext);
		lim_read = ext ? {v[15:3], 3'h0} : {v[15:4], 4'h0};
	endfunction

	logic sd, pol, mode, ext;
	logic [1:0] rate, depth;
	logic ctrl_wr, base_tick, per_fire, shot_req, start, act;
	logic hi_cond, lo_cond, q_upd, hi_q, lo_q;

	assign sd = st_r.ctrl[tsca_pkg::B_SD];
	assign pol = st_r.ctrl[tsca_pkg::B_POL];
	assign mode = st_r.ctrl[tsca_pkg::B_MODE];
	assign ext = st_r.ctrl[tsca_pkg::B_EXT];
	assign rate = st_r.ctrl[tsca_pkg::B_RATE +: 2];
	assign depth = st_r.ctrl[tsca_pkg::B_FAULT +: 2];

	assign ctrl_wr = reg_wr && (reg_addr == tsca_pkg::ADDR_CTRL);
	assign base_tick = st_r.tick == 32'(BASE_CYC - 1);
	assign per_fire = base_tick && (st_r.per_cnt >= rate_mult(rate) - 6'h01) && !sd;
	assign shot_req = ctrl_wr && reg_wdata[tsca_pkg::B_ONESHOT] && reg_wdata[tsca_pkg::B_SD];
	assign start = (per_fire || shot_req) && !st_r.busy;
	assign act = mode ? st_r.ev : st_r.comp;

	assign hi_cond = $signed(st_r.temp) >= $signed(lim_raw(st_r.thigh, ext));
	assign lo_cond = $signed(st_r.temp) < $signed(lim_raw(st_r.tlow, ext));

	tsca_fault_q #(
		.CW(3)
	) u_fq (
		.clk(clk),
		.rst(rst),
		.sample(st_r.landed),
		.hi_cond(hi_cond),
		.lo_cond(lo_cond),
		.depth(depth),
		.upd(q_upd),
		.hi_q(hi_q),
		.lo_q(lo_q)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	// The limit compare looks at the result one cycle after it lands, so the
	// fault queue always judges the newest conversion.
	always_comb begin
		st_nxt = st_r;
		st_nxt.adc_start = 1'b0;
		st_nxt.landed = adc_done && st_r.busy;
		st_nxt.tick = base_tick ? '0 : st_r.tick + 32'h0000_0001;
		if (base_tick) begin
			st_nxt.per_cnt = (st_r.per_cnt >= rate_mult(rate) - 6'h01) ? '0 : st_r.per_cnt + 6'h01;
		end
		if (start) begin
			st_nxt.busy = 1'b1;
			st_nxt.adc_start = 1'b1;
		end
		if (adc_done && st_r.busy) begin
			st_nxt.busy = 1'b0;
			st_nxt.temp = adc_data;
		end
		if (ctrl_wr) begin
			st_nxt.ctrl = (reg_wdata & tsca_pkg::CTRL_WMASK) | (st_r.ctrl & ~tsca_pkg::CTRL_WMASK);
		end
		if (reg_wr && reg_addr == tsca_pkg::ADDR_TLOW) begin
			st_nxt.tlow = reg_wdata;
		end
		if (reg_wr && reg_addr == tsca_pkg::ADDR_THIGH) begin
			st_nxt.thigh = reg_wdata;
		end
		// Any register read clears the event latch; a qualified event in the same cycle wins.
		if (reg_rd) begin
			st_nxt.ev = 1'b0;
		end
		if (q_upd) begin
			if (hi_q) begin
				st_nxt.comp = 1'b1;
			end else if (lo_q) begin
				st_nxt.comp = 1'b0;
			end
			if (!st_r.ev_dir && hi_q) begin
				st_nxt.ev = 1'b1;
				st_nxt.ev_dir = 1'b1;
			end else if (st_r.ev_dir && lo_q) begin
				st_nxt.ev = 1'b1;
				st_nxt.ev_dir = 1'b0;
			end
		end
		st_nxt.alert = pol ? act : !act;
		if (reg_rd) begin
			unique case (reg_addr)
				tsca_pkg::ADDR_TEMP: st_nxt.rdata = ext ? {st_r.temp, 3'h1} : {st_r.temp[11:0], 4'h0};
				tsca_pkg::ADDR_CTRL: begin
					st_nxt.rdata = st_r.ctrl | tsca_pkg::CTRL_RSV_ONES;
					st_nxt.rdata[tsca_pkg::B_ONESHOT] = sd && !st_r.busy;
					st_nxt.rdata[tsca_pkg::B_FLAG] = pol ? st_r.comp : !st_r.comp;
				end
				tsca_pkg::ADDR_TLOW: st_nxt.rdata = lim_read(st_r.tlow, ext);
				tsca_pkg::ADDR_THIGH: st_nxt.rdata = lim_read(st_r.thigh, ext);
				default: st_nxt.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '{ctrl: tsca_pkg::CTRL_RST, tlow: tsca_pkg::TLOW_RST, thigh: tsca_pkg::THIGH_RST,
				alert: 1'b1, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign adc_start = st_r.adc_start;
	assign alert_out = st_r.alert;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_ctrl_rd;
		reg_rd && reg_addr == tsca_pkg::ADDR_CTRL;
	endsequence

	sequence s_shot_wr(logic sdv);
		ctrl_wr && reg_wdata[tsca_pkg::B_ONESHOT] && reg_wdata[tsca_pkg::B_SD] == sdv;
	endsequence

	property p_shot_start;
		s_shot_wr(1'b1) ##0 !st_r.busy |=> adc_start && st_r.busy;
	endproperty
	a_shot_start: assert property (p_shot_start) else $error("one-shot in standby did not start");

	property p_shot_cont;
		s_shot_wr(1'b0) ##0 !per_fire |=> !adc_start;
	endproperty
	a_shot_cont: assert property (p_shot_cont) else $error("one-shot started in continuous mode");

	property p_oneshot_cont;
		s_ctrl_rd ##0 !sd |=> !reg_rdata[tsca_pkg::B_ONESHOT];
	endproperty
	a_oneshot_cont: assert property (p_oneshot_cont) else $error("one-shot bit not 0 in continuous");

	property p_oneshot_busy;
		s_ctrl_rd ##0 sd |=> reg_rdata[tsca_pkg::B_ONESHOT] == !$past(st_r.busy);
	endproperty
	a_oneshot_busy: assert property (p_oneshot_busy) else $error("one-shot bit wrong in standby");

	property p_alert_level;
		1'b1 |=> alert_out == ($past(pol) ? $past(act) : !$past(act));
	endproperty
	a_alert_level: assert property (p_alert_level) else $error("event pin level wrong");

	property p_ev_clear;
		reg_rd && mode && st_r.ev && !q_upd |=> !st_r.ev ##1 !alert_out == pol;
	endproperty
	a_ev_clear: assert property (p_ev_clear) else $error("event not cleared by read");

	property p_standby;
		sd |-> !per_fire;
	endproperty
	a_standby: assert property (p_standby) else $error("periodic conversion in standby");

	property p_period;
		base_tick && st_r.per_cnt >= rate_mult(rate) - 6'h01 |=> st_r.per_cnt == 6'h00;
	endproperty
	a_period: assert property (p_period) else $error("period counter beyond rate");

	property p_flag;
		s_ctrl_rd |=> reg_rdata[tsca_pkg::B_FLAG] == ($past(pol) ~^ $past(st_r.comp));
	endproperty
	a_flag: assert property (p_flag) else $error("status flag wrong");

	property p_temp_fmt;
		reg_rd && reg_addr == tsca_pkg::ADDR_TEMP |=> ($past(ext) ? reg_rdata[2:0] == 3'h1 : reg_rdata[3:0] == 4'h0);
	endproperty
	a_temp_fmt: assert property (p_temp_fmt) else $error("temperature low bits wrong");

	property p_rsv;
		s_ctrl_rd |=> reg_rdata[14:13] == 2'h3 && reg_rdata[3:0] == 4'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved control bits wrong");

endmodule

// File: sim/tsca_adc_model.sv
`timescale 1ns/1ps
module tsca_adc_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Converter handshake
	input wire logic start,
	output logic done,
	output logic [12:0] data,
	// Result and delay chosen by the bench
	input wire logic [12:0] result,
	input wire logic [3:0] lat
);
	int cnt;

	initial begin
		done = 1'b0;
		data = 13'h0000;
		cnt = -1;
	end

	// Outside its valid cycle the data is inverted on every cycle, so a stale sample matches the result only every other cycle.
	always @(negedge clk) begin
		done <= 1'b0;
		data <= ~data;
		if (rst) begin
			cnt <= -1;
		end else if (cnt == 0) begin
			done <= 1'b1;
			data <= result;
			cnt <= -1;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end else if (start) begin
			cnt <= lat;
		end
	end
endmodule

// File: sim/tb_temp_sensor_config_alert.sv
`timescale 1ns/1ps
module tb_temp_sensor_config_alert;
	localparam int BC = 20;
	logic clk;
	logic rst;
	logic [7:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic adc_start;
	logic adc_done;
	logic [12:0] adc_data;
	logic alert_out;
	logic [12:0] result;
	logic [3:0] lat;
	logic [15:0] rv;
	logic [15:0] w;
	logic [12:0] d;
	int num_errors = 0;
	int n_compared = 0;
	int seed = 17664;
	int cyc = 0;
	int n;
	int t[3];
	int mult[4] = '{32, 8, 2, 1};
	int fq[4] = '{1, 2, 4, 6};

	tsca_top #(.BASE_CYC(BC)) u_tsca_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_start(adc_start),
		.adc_done(adc_done), .adc_data(adc_data), .alert_out(alert_out));
	tsca_adc_model u_tsca_adc_model (.clk(clk), .rst(rst), .start(adc_start), .done(adc_done),
		.data(adc_data), .result(result), .lat(lat));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// The slowest phase needs three 4 s periods of the shortened timebase; the ceiling leaves ample room.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] ctrl_exp(input logic [15:0] v, input logic comp);
		ctrl_exp = (v & 16'h1FD0) | 16'h6000 | {v[8], 9'h000, ~(v[10] ^ comp), 5'h00};
	endfunction

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		rv = reg_rdata;
	endtask

	task automatic start_at(output int tt);
		for (n = 0; n < 700; n++) begin
			@(posedge clk);
			#1;
			if (adc_start === 1'b1) break;
		end
		tt = cyc;
	endtask

	// One-shot conversion in standby; returns once the alert level has settled.
	task automatic conv(input logic [15:0] c, input logic [12:0] dd);
		result = dd;
		lat = 4'(($random(seed) & 7) + 1);
		wr(8'h01, c | 16'h8100);
		check("oneshot_start", {15'h0000, adc_start}, 16'h0001);
		for (n = 0; n < 20 && adc_done !== 1'b1; n++) @(posedge clk);
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic results();
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
		result = 13'h0064;
		lat = 4'h2;
		repeat (20) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		check("alert_idle", {15'h0000, alert_out}, 16'h0001);
		rd(8'h01);
		check("ctrl_reset", rv, 16'h60A0);
		rd(8'h80 | 8'($random(seed)));
		check("unmapped", rv, 16'h0000);
		for (int r = 3; r >= 0; r--) begin
			wr(8'h01, 16'(r << 6));
			start_at(t[0]);
			start_at(t[1]);
			start_at(t[2]);
			check("period", 16'(t[2] - t[1]), 16'(BC * mult[r]));
		end
		wr(8'h01, 16'h8000);
		n = 0;
		repeat (30) begin
			n += int'(adc_start);
			@(posedge clk);
			#1;
		end
		check("cont_trigger", 16'(n), 16'h0000);
		rd(8'h01);
		check("ctrl_cont", rv, 16'h6020);
		wr(8'h01, 16'h7FFF);
		rd(8'h01);
		check("ctrl_ro", rv, 16'hFFD0);
		n = 0;
		repeat (700) begin
			@(posedge clk);
			#1;
			n += int'(adc_start);
		end
		check("standby_quiet", 16'(n), 16'h0000);
		repeat (4) begin
			w = 16'($random(seed)) & 16'h7EFF;
			wr(8'h01, w);
			rd(8'h01);
			check("ctrl_rand", rv, ctrl_exp(w, 1'b0));
		end
		// Back to standby and let any periodic conversion drain, so the next one-shot is not dropped.
		wr(8'h01, 16'h0100);
		repeat (8) @(negedge clk);
		wr(8'h03, 16'h1900);
		wr(8'h02, 16'h1400);
		for (int q = 0; q < 4; q++) begin
			w = 16'h0500 | 16'(q << 11);
			for (int k = 0; k < 2; k++) begin
				for (int i = 0; i < fq[q]; i++) begin
					d = (k == 0) ? 13'(400 + ($random(seed) & 63)) : 13'(100 + ($random(seed) & 127));
					conv(w, d);
					check("alert_queue", {15'h0000, alert_out}, {15'h0000, (i == fq[q] - 1) ^ (k == 1)});
				end
				rd(8'h01);
				check("flag", rv, ctrl_exp(w, k == 0));
			end
		end
		result = 13'h0064;
		lat = 4'h8;
		wr(8'h01, 16'h8100);
		rd(8'h01);
		check("oneshot_busy", rv, ctrl_exp(16'h0100, 1'b0) & 16'h7FFF);
		repeat (20) @(posedge clk);
		rd(8'h01);
		check("oneshot_done", rv, ctrl_exp(16'h0100, 1'b0));
		conv(16'h0300, 13'h01A0);
		check("event_hi", {15'h0000, alert_out}, 16'h0000);
		rd(8'h01);
		check("event_flag", rv, ctrl_exp(16'h0300, 1'b1));
		repeat (3) @(posedge clk);
		#1;
		check("event_clear", {15'h0000, alert_out}, 16'h0001);
		conv(16'h0300, 13'h0064);
		check("event_lo", {15'h0000, alert_out}, 16'h0000);
		d = 13'($random(seed));
		conv(16'h0100, d);
		rd(8'h00);
		check("temp_norm", rv, {d[11:0], 4'h0});
		wr(8'h01, 16'h0110);
		wr(8'h03, 16'h0C80);
		wr(8'h02, 16'h0A00);
		d = 13'($random(seed));
		conv(16'h0110, d);
		rd(8'h00);
		check("temp_ext", rv, {d, 3'b001});
		results();
	end
endmodule
